/* File: common/ppm_pkg.sv */
/*
 * constants for the port pin mux block: register indices, reset values,
 * field positions and pin-to-function index mapping.
 * assumes an 8-bit register port with a 4-bit register index.
 */
package ppm_pkg;

  // ************************************************************
  // register port
  // ************************************************************
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] REG_PE_LEVELS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_PE_LATCH = 4'h1;
  localparam logic [ADDR_W-1:0] REG_PE_DIR = 4'h2;
  localparam logic [ADDR_W-1:0] REG_PF_LEVELS = 4'h3;
  localparam logic [ADDR_W-1:0] REG_PF_LATCH = 4'h4;
  localparam logic [ADDR_W-1:0] REG_PF_DIR = 4'h5;
  localparam logic [ADDR_W-1:0] REG_SEG_MID = 4'h6;
  localparam logic [ADDR_W-1:0] REG_SEG_UPPER = 4'h7;
  localparam logic [ADDR_W-1:0] REG_CMP_CTRL = 4'h8;
  localparam logic [ADDR_W-1:0] REG_AN_FIRST = 4'h9;
  localparam logic [ADDR_W-1:0] REG_AN_SECOND = 4'ha;
  localparam logic [ADDR_W-1:0] REG_OD_FIRST = 4'hb;
  localparam logic [ADDR_W-1:0] REG_OD_SECOND = 4'hc;
  localparam logic [ADDR_W-1:0] REG_PAD_CFG = 4'hd;
  localparam logic [ADDR_W-1:0] REG_ALT_CTRL = 4'he;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [DATA_W-1:0] RST_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] RST_DIR = 8'hff;
  localparam logic [DATA_W-1:0] RST_ANALOG = 8'hff;
  localparam logic [DATA_W-1:0] RST_ALT = 8'h01;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int ALT_CCPB_SEL_BIT = 0;
  localparam int ALT_SHDN_TRI_BIT = 1;
  localparam int CMP_C1_EN_BIT = 0;
  localparam int CMP_C2_EN_BIT = 1;
  localparam int CMP_C1_OE_BIT = 2;
  localparam int CMP_C2_OE_BIT = 3;
  localparam int OD1_CCP2_BIT = 6;
  localparam int PAD_REPU_BIT = 6;
  localparam int E_TOP_BIT = 7;
  localparam logic [DATA_W-1:0] OD2_SMALL_MASK = 8'h3f;
  localparam logic [DATA_W-1:0] PAD_CFG_MASK = 8'he6;
  localparam logic [DATA_W-1:0] OD1_MASK = 8'he1;
  localparam logic [DATA_W-1:0] CMP_MASK = 8'h0f;
  localparam logic [DATA_W-1:0] ALT_MASK = 8'h03;

  // ************************************************************
  // pin to segment / analog channel mapping
  // ************************************************************
  localparam int SEG_BASE = 16;
  localparam int SEG_E_TOP = 31;
  localparam int RF_SEG_OFS = 18;
  localparam int RF_AN_OFS = 5;
  localparam int RF_TOP = 7;
  localparam int RF_TOP_SEG = 25;
  localparam int RF_TOP_AN = 5;
  localparam int SMALL_MEM_KB = 32;

endpackage : ppm_pkg

/* File: hdl/ppm_pin_drive.sv */
/*
 * output driver selection for one pin: latch or alternate data,
 * direction, forced tri-state, open drain and segment disable.
 * assumes all inputs come from logic on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module ppm_pin_drive (
  input wire logic latch_bit,
  input wire logic dir_bit,
  input wire logic alt_en,
  input wire logic alt_data,
  input wire logic force_tri,
  input wire logic open_drain,
  input wire logic seg_en,
  output logic pin_out,
  output logic pin_oe
);
  logic drive;

  always_comb begin
    // alternate function wins over latch data while it owns the pin
    pin_out = alt_en ? alt_data : latch_bit;
    // a zero direction bit means output
    drive = !dir_bit && !force_tri && !seg_en;
    // open drain only pulls low
    pin_oe = drive && !(open_drain && pin_out);
  end
endmodule : ppm_pin_drive
`default_nettype wire

/* File: hdl/ppm_port_mux.sv */
/*
 * port mux for the top pin of port e and the seven pins of port f:
 * direction and latch registers, alternate capture/pwm, comparator and
 * lcd segment overrides, analog select, open drain and pad config.
 * assumes an 8-bit register port with read data one cycle after the read
 * strobe, and comparator / capture unit signals on ref_clk.
 */
// Added by the designer: the register offsets and the address-and-strobe port.
// How it works
// - port f: seven pins, each own direction
// - direction and latch registers; outputs drive latch
// - direction one input, zero output
// - capture unit output beats latch; else capture
// - capture unit routed only when select cleared
// - pwm output tri-stated during shutdown, optionally
// - segment 31 enabled disables top pin driver
// - function-owned pins still need a zero direction bit to drive
// - all port f inputs are schmitt buffered
// - pins one to six carry comparator signals
// - reset: port f pins analog, their digital reads zero
// - segment enabled pins lose port functions
// - small memory parts lack two open-drain bits
`timescale 1ns/10ps
`default_nettype none
module ppm_port_mux #(
  parameter int PROG_MEM_KB = 64
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ppm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ppm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ppm_pkg::DATA_W-1:0] reg_rdata,
  input wire logic e_top_pin_in,
  output logic e_top_pin_out,
  output logic e_top_pin_oe,
  input wire logic [7:1] f_pin_in,
  output logic [7:1] f_pin_out,
  output logic [7:1] f_pin_oe,
  input wire logic ccp_b_out,
  input wire logic ccp_b_out_en,
  input wire logic pwm_shutdown,
  output logic ccp_b_capture,
  input wire logic comp1_out,
  input wire logic comp2_out,
  output logic [1:0] comp_enable,
  output logic e_pullup_en
);
  import ppm_pkg::*;

  // ************************************************************
  // elaboration checks
  // ************************************************************
  generate
    if (PROG_MEM_KB <= 0) begin : g_bad_mem
      $error("ppm_port_mux: PROG_MEM_KB must be positive");
    end
  endgenerate

  localparam bit SMALL_MEM = (PROG_MEM_KB == SMALL_MEM_KB);
  // the two top open-drain bits only exist on larger parts
  localparam logic [DATA_W-1:0] OD2_MASK = SMALL_MEM ? OD2_SMALL_MASK : 8'hff;

  // ************************************************************
  // index helpers
  // ************************************************************
  function automatic logic [3:0] seg_idx(input int k);
    int s;
    s = (k == RF_TOP) ? RF_TOP_SEG : RF_SEG_OFS + k;
    return 4'(s - SEG_BASE);
  endfunction : seg_idx

  function automatic logic [3:0] an_idx(input int k);
    int a;
    a = (k == RF_TOP) ? RF_TOP_AN : RF_AN_OFS + k;
    return 4'(a);
  endfunction : an_idx

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] r);
    return a == r;
  endfunction : hit

  // ************************************************************
  // registers
  // ************************************************************
  logic [DATA_W-1:0] pe_latch_q;
  logic [DATA_W-1:0] pe_dir_q;
  logic [7:1] pf_latch_q;
  logic [7:1] pf_dir_q;
  logic [DATA_W-1:0] seg_mid_q;
  logic [DATA_W-1:0] seg_upper_q;
  logic [DATA_W-1:0] cmp_ctrl_q;
  logic [DATA_W-1:0] an_first_q;
  logic [DATA_W-1:0] an_second_q;
  logic [DATA_W-1:0] od_first_q;
  logic [DATA_W-1:0] od_second_q;
  logic [DATA_W-1:0] pad_cfg_q;
  logic [DATA_W-1:0] alt_ctrl_q;
  logic [DATA_W-1:0] rdata_d;
  logic ccp_capture_d;

  // a write to the level register lands in the latch, same as a latch write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pe_latch_q <= RST_ZERO;
      pf_latch_q <= RST_ZERO[7:1];
    end else if (reg_wr) begin
      if (hit(reg_addr, REG_PE_LEVELS) || hit(reg_addr, REG_PE_LATCH)) begin
        pe_latch_q <= reg_wdata;
      end
      if (hit(reg_addr, REG_PF_LEVELS) || hit(reg_addr, REG_PF_LATCH)) begin
        pf_latch_q <= reg_wdata[7:1];
      end
    end
  end

  // directions come out of reset as inputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pe_dir_q <= RST_DIR;
      pf_dir_q <= RST_DIR[7:1];
    end else if (reg_wr) begin
      if (hit(reg_addr, REG_PE_DIR)) begin
        pe_dir_q <= reg_wdata;
      end
      if (hit(reg_addr, REG_PF_DIR)) begin
        pf_dir_q <= reg_wdata[7:1];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seg_mid_q <= RST_ZERO;
      seg_upper_q <= RST_ZERO;
    end else if (reg_wr) begin
      if (hit(reg_addr, REG_SEG_MID)) begin
        seg_mid_q <= reg_wdata;
      end
      if (hit(reg_addr, REG_SEG_UPPER)) begin
        seg_upper_q <= reg_wdata;
      end
    end
  end

  // analog selects reset to analog so pins start as analog inputs
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      an_first_q <= RST_ANALOG;
      an_second_q <= RST_ANALOG;
      cmp_ctrl_q <= RST_ZERO;
    end else if (reg_wr) begin
      if (hit(reg_addr, REG_AN_FIRST)) begin
        an_first_q <= reg_wdata;
      end
      if (hit(reg_addr, REG_AN_SECOND)) begin
        an_second_q <= reg_wdata;
      end
      if (hit(reg_addr, REG_CMP_CTRL)) begin
        cmp_ctrl_q <= reg_wdata & CMP_MASK;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      od_first_q <= RST_ZERO;
      od_second_q <= RST_ZERO;
      pad_cfg_q <= RST_ZERO;
      alt_ctrl_q <= RST_ALT;
    end else if (reg_wr) begin
      if (hit(reg_addr, REG_OD_FIRST)) begin
        od_first_q <= reg_wdata & OD1_MASK;
      end
      if (hit(reg_addr, REG_OD_SECOND)) begin
        od_second_q <= reg_wdata & OD2_MASK;
      end
      if (hit(reg_addr, REG_PAD_CFG)) begin
        pad_cfg_q <= reg_wdata & PAD_CFG_MASK;
      end
      if (hit(reg_addr, REG_ALT_CTRL)) begin
        alt_ctrl_q <= reg_wdata & ALT_MASK;
      end
    end
  end

  // ************************************************************
  // pin input path
  // ************************************************************
  logic e_top_sync;
  logic [7:1] f_sync;
  logic [15:0] seg_all;
  logic [15:0] an_all;
  logic [7:1] f_seg_en;
  logic [7:1] f_analog;
  logic [7:1] f_dig_in;
  logic e_top_seg;
  logic e_top_dig;

  // pin levels cross into ref_clk; the pad's schmitt buffer sits in front
  ppm_sync #(.W(1)) u_sync_e (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(e_top_pin_in),
    .sync_out(e_top_sync)
  );

  ppm_sync #(.W(7)) u_sync_f (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(f_pin_in),
    .sync_out(f_sync)
  );

  assign seg_all = {seg_upper_q, seg_mid_q};
  assign an_all = {an_second_q, an_first_q};
  assign e_top_seg = seg_all[4'(SEG_E_TOP - SEG_BASE)];

  // comparator inputs sit on pins 3..6: an enabled comparator blocks them
  always_comb begin
    for (int k = 1; k <= 7; k++) begin
      f_seg_en[k] = seg_all[seg_idx(k)];
      f_analog[k] = an_all[an_idx(k)];
    end
    f_dig_in = f_sync & ~f_seg_en & ~f_analog;
    if (cmp_ctrl_q[CMP_C2_EN_BIT]) begin
      f_dig_in[4:3] = 2'h0;
    end
    if (cmp_ctrl_q[CMP_C1_EN_BIT]) begin
      f_dig_in[6:5] = 2'h0;
    end
    e_top_dig = e_top_sync && !e_top_seg;
  end

  // ************************************************************
  // top pin of port e: capture/compare unit, pwm shutdown, segment
  // ************************************************************
  logic ccp_routed;
  logic ccp_drive;
  logic ccp_tri;
  logic ccp_od;

  assign ccp_routed = !alt_ctrl_q[ALT_CCPB_SEL_BIT];
  assign ccp_drive = ccp_routed && ccp_b_out_en;
  assign ccp_tri = ccp_drive && alt_ctrl_q[ALT_SHDN_TRI_BIT] && pwm_shutdown;
  assign ccp_od = ccp_drive && od_first_q[OD1_CCP2_BIT];

  ppm_pin_drive u_drive_e (
    .latch_bit(pe_latch_q[E_TOP_BIT]),
    .dir_bit(pe_dir_q[E_TOP_BIT]),
    .alt_en(ccp_drive),
    .alt_data(ccp_b_out),
    .force_tri(ccp_tri),
    .open_drain(ccp_od),
    .seg_en(e_top_seg),
    .pin_out(e_top_pin_out),
    .pin_oe(e_top_pin_oe)
  );

  // capture input only sees the pin while the unit owns it as an input
  assign ccp_capture_d = ccp_routed && pe_dir_q[E_TOP_BIT] && e_top_dig;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ccp_b_capture <= 1'b0;
    end else begin
      ccp_b_capture <= ccp_capture_d;
    end
  end

  // ************************************************************
  // port f drivers: comparator outputs on pins 1 and 2
  // ************************************************************
  logic [7:1] f_alt_en;
  logic [7:1] f_alt_data;

  always_comb begin
    f_alt_en = '0;
    f_alt_data = '0;
    f_alt_en[1] = cmp_ctrl_q[CMP_C2_EN_BIT] && cmp_ctrl_q[CMP_C2_OE_BIT];
    f_alt_data[1] = comp2_out;
    f_alt_en[2] = cmp_ctrl_q[CMP_C1_EN_BIT] && cmp_ctrl_q[CMP_C1_OE_BIT];
    f_alt_data[2] = comp1_out;
  end

  // a segment-owned pin is driven off whatever its direction bit says
  genvar gk;
  generate
    for (gk = 1; gk <= 7; gk++) begin : g_pf
      ppm_pin_drive u_drive_f (
        .latch_bit(pf_latch_q[gk]),
        .dir_bit(pf_dir_q[gk]),
        .alt_en(f_alt_en[gk]),
        .alt_data(f_alt_data[gk]),
        .force_tri(1'b0),
        .open_drain(1'b0),
        .seg_en(f_seg_en[gk]),
        .pin_out(f_pin_out[gk]),
        .pin_oe(f_pin_oe[gk])
      );
    end
  endgenerate

  assign comp_enable = {cmp_ctrl_q[CMP_C2_EN_BIT], cmp_ctrl_q[CMP_C1_EN_BIT]};
  assign e_pullup_en = pad_cfg_q[PAD_REPU_BIT];

  // ************************************************************
  // read path
  // ************************************************************
  // only the top pin of port e lives here; its level read shows the lower seven as zero
  always_comb begin
    rdata_d = RST_ZERO;
    case (reg_addr)
      REG_PE_LEVELS: rdata_d = {e_top_dig, 7'h00};
      REG_PE_LATCH: rdata_d = pe_latch_q;
      REG_PE_DIR: rdata_d = pe_dir_q;
      REG_PF_LEVELS: rdata_d = {f_dig_in, 1'b0};
      REG_PF_LATCH: rdata_d = {pf_latch_q, 1'b0};
      REG_PF_DIR: rdata_d = {pf_dir_q, 1'b1};
      REG_SEG_MID: rdata_d = seg_mid_q;
      REG_SEG_UPPER: rdata_d = seg_upper_q;
      REG_CMP_CTRL: rdata_d = cmp_ctrl_q;
      REG_AN_FIRST: rdata_d = an_first_q;
      REG_AN_SECOND: rdata_d = an_second_q;
      REG_OD_FIRST: rdata_d = od_first_q;
      REG_OD_SECOND: rdata_d = od_second_q;
      REG_PAD_CFG: rdata_d = pad_cfg_q;
      REG_ALT_CTRL: rdata_d = alt_ctrl_q;
      default: rdata_d = RST_ZERO;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= RST_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= RST_ZERO;
    end
  end

endmodule : ppm_port_mux
`default_nettype wire

/* File: hdl/ppm_sync.sv */
/*
 * two flip-flop level synchroniser, one lane per bit.
 * assumes inputs are asynchronous pin levels.
 */
`timescale 1ns/10ps
`default_nettype none
module ppm_sync #(
  parameter int W = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // the first stage feeds only the second stage
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : ppm_sync
`default_nettype wire

/* File: testbench/port_pin_mux_e7_and_f_tb.sv */
/*
 * self-checking bench for the port pin mux with a board model.
 * assumes ppm_pkg is compiled first and the checker is bound.
 */
`timescale 1ns/10ps
`default_nettype none
module port_pin_mux_e7_and_f_tb;
  import ppm_pkg::*;
  localparam logic [7:0] RST_V [16] = '{8'h80, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff,
    8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ccp_out = 1'b0, ccp_en = 1'b0, shdn = 1'b0, c1 = 1'b0, c2 = 1'b0;
  logic e_drv = 1'b1;
  logic [7:1] f_drv = 7'h7f;
  logic rd_taken = 1'b0;
  logic [3:0] rd_addr = 4'h0;
  logic [7:0] reg_rdata, v, d, rdata_small, rd_exp;
  logic e_in, e_out, e_oe, cap, pu;
  logic [7:1] f_in, f_out, f_oe;
  logic [1:0] comp_en;
  logic [7:0] exp_q [$];
  int error_cnt = 0;
  int tests_run = 0;

  ppm_port_mux dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .e_top_pin_in(e_in),
    .e_top_pin_out(e_out), .e_top_pin_oe(e_oe), .f_pin_in(f_in), .f_pin_out(f_out),
    .f_pin_oe(f_oe), .ccp_b_out(ccp_out), .ccp_b_out_en(ccp_en), .pwm_shutdown(shdn),
    .ccp_b_capture(cap), .comp1_out(c1), .comp2_out(c2), .comp_enable(comp_en),
    .e_pullup_en(pu)
  );
  // small memory part beside the main one: same stimulus, two open-drain bits absent
  ppm_port_mux #(.PROG_MEM_KB(SMALL_MEM_KB)) dut_small (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_small), .e_top_pin_in(e_in),
    .e_top_pin_out(), .e_top_pin_oe(), .f_pin_in(f_in), .f_pin_out(), .f_pin_oe(),
    .ccp_b_out(ccp_out), .ccp_b_out_en(ccp_en), .pwm_shutdown(shdn), .ccp_b_capture(),
    .comp1_out(c1), .comp2_out(c2), .comp_enable(), .e_pullup_en()
  );
  ppm_board board (
    .e_oe(e_oe), .e_out(e_out), .f_oe(f_oe), .f_out(f_out), .e_drv(e_drv),
    .f_drv(f_drv), .e_lvl(e_in), .f_lvl(f_in)
  );

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // strobes stay up between back-to-back cycles; cyc drops them
  task automatic wr(input logic [3:0] a, input logic [7:0] w);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask : rd
  task automatic cyc(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask : cyc
  task automatic wrap_up;
    if (error_cnt == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // ************************************************************
  // read data monitor and watchdog
  // ************************************************************
  always @(posedge ref_clk) begin
    rd_taken <= reg_rd;
    rd_addr <= reg_addr;
  end
  always @(negedge ref_clk) begin
    if (rd_taken && exp_q.size() > 0) begin
      rd_exp = exp_q.pop_front();
      chk(reg_rdata, rd_exp);
      chk(rdata_small, (rd_addr == REG_OD_SECOND) ? rd_exp & OD2_SMALL_MASK : rd_exp);
    end
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    wrap_up();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    void'($urandom(32'hee830eba));
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(3);
    @(negedge ref_clk);
    chk({e_oe, f_oe}, 8'h00);
    @(posedge ref_clk);
    foreach (RST_V[i]) rd(4'(i), RST_V[i]);
    wr(REG_PAD_CFG, 8'hff);
    wr(REG_OD_FIRST, 8'hff);
    wr(REG_OD_SECOND, 8'hff);
    wr(4'hf, 8'hff);
    rd(REG_PAD_CFG, 8'he6);
    rd(REG_OD_FIRST, 8'he1);
    rd(REG_OD_SECOND, 8'hff);
    rd(4'hf, 8'h00);
    // software hands port f to digital use first
    wr(REG_AN_FIRST, 8'h00);
    wr(REG_AN_SECOND, 8'h00);
    cyc(1);
    @(negedge ref_clk);
    chk({7'h0, pu}, 8'h01);
    @(posedge ref_clk);
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      d = $urandom;
      wr(REG_PF_LATCH, v);
      wr(REG_PF_DIR, d);
      wr(REG_PE_LEVELS, v);
      wr(REG_PE_DIR, d);
      rd(REG_PF_LATCH, v & 8'hfe);
      rd(REG_PF_DIR, d | 8'h01);
      rd(REG_PE_LATCH, v);
      cyc(1);
      @(negedge ref_clk);
      chk({1'b0, f_oe}, {1'b0, ~d[7:1]});
      chk({1'b0, f_out & f_oe}, {1'b0, v[7:1] & ~d[7:1]});
      chk({6'h0, e_oe, e_out & e_oe}, {6'h0, ~d[7], v[7] & ~d[7]});
      @(posedge ref_clk);
    end
    f_drv <= d[7:1];
    wr(REG_PF_DIR, 8'hff);
    wr(REG_AN_FIRST, 8'h20);
    cyc(3);
    rd(REG_PF_LEVELS, {1'b0, d[6:1], 1'b0});
    wr(REG_AN_FIRST, 8'h00);
    cyc(3);
    rd(REG_PF_LEVELS, {d[7:1], 1'b0});
    f_drv <= 7'h7f;
    wr(REG_CMP_CTRL, 8'h03);
    cyc(3);
    rd(REG_PF_LEVELS, 8'h86);
    wr(REG_PF_DIR, 8'h00);
    wr(REG_CMP_CTRL, 8'h0f);
    c1 <= d[0];
    c2 <= ~d[0];
    cyc(1);
    @(negedge ref_clk);
    chk({4'h0, comp_en, f_out[2:1]}, {4'h0, 2'b11, d[0], ~d[0]});
    @(posedge ref_clk);
    wr(REG_CMP_CTRL, 8'h00);
    wr(REG_SEG_MID, 8'hf8);
    wr(REG_SEG_UPPER, 8'h83);
    wr(REG_PE_DIR, 8'h00);
    cyc(1);
    @(negedge ref_clk);
    chk({e_oe, f_oe}, 8'h00);
    @(posedge ref_clk);
    wr(REG_PF_DIR, 8'hff);
    cyc(3);
    rd(REG_PF_LEVELS, 8'h00);
    rd(REG_PE_LEVELS, 8'h00);
    wr(REG_SEG_MID, 8'h00);
    wr(REG_SEG_UPPER, 8'h00);
    wr(REG_OD_FIRST, 8'h00);
    wr(REG_ALT_CTRL, 8'h00);
    ccp_en <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      ccp_out <= i[0];
      shdn <= i[1];
      cyc(1);
      @(negedge ref_clk);
      chk({6'h0, e_oe, e_out}, {6'h0, 1'b1, i[0]});
      @(posedge ref_clk);
    end
    wr(REG_ALT_CTRL, 8'h02);
    cyc(1);
    @(negedge ref_clk);
    chk({7'h0, e_oe}, 8'h00);
    @(posedge ref_clk);
    shdn <= 1'b0;
    wr(REG_OD_FIRST, 8'h40);
    cyc(1);
    @(negedge ref_clk);
    chk({6'h0, e_oe, e_out}, 8'h01);
    @(posedge ref_clk);
    ccp_out <= 1'b0;
    cyc(1);
    @(negedge ref_clk);
    chk({6'h0, e_oe, e_out}, 8'h02);
    @(posedge ref_clk);
    wr(REG_ALT_CTRL, 8'h01);
    cyc(1);
    @(negedge ref_clk);
    chk({6'h0, e_oe, e_out}, {6'h0, 1'b1, v[7]});
    @(posedge ref_clk);
    wr(REG_PE_DIR, 8'h80);
    wr(REG_ALT_CTRL, 8'h00);
    cyc(4);
    @(negedge ref_clk);
    chk({7'h0, cap}, 8'h01);
    @(posedge ref_clk);
    // a low pin must reach the capture input as well
    e_drv <= 1'b0;
    cyc(4);
    @(negedge ref_clk);
    chk({7'h0, cap}, 8'h00);
    @(posedge ref_clk);
    e_drv <= 1'b1;
    wr(REG_ALT_CTRL, 8'h01);
    cyc(4);
    @(negedge ref_clk);
    chk({7'h0, cap}, 8'h00);
    @(posedge ref_clk);
    // a second reset in mid-run must bring the defaults back
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(3);
    rd(REG_PE_DIR, 8'hff);
    rd(REG_AN_FIRST, 8'hff);
    cyc(3);
    wrap_up();
  end
endmodule : port_pin_mux_e7_and_f_tb
`default_nettype wire

/* File: testbench/ppm_board.sv */
/*
 * board side of the port pins: each pin shows the block's value where
 * the block drives it, else the level the bench puts on the board.
 * assumes the bench sets e_drv and f_drv; DLY models a slow board.
 */
`timescale 1ns/10ps
`default_nettype none
module ppm_board #(
  parameter int DLY = 1
) (
  input wire logic e_oe,
  input wire logic e_out,
  input wire logic [7:1] f_oe,
  input wire logic [7:1] f_out,
  input wire logic e_drv,
  input wire logic [7:1] f_drv,
  output logic e_lvl,
  output logic [7:1] f_lvl
);
  // ************************************************************
  // pin levels
  // ************************************************************
  // the board gives way on every pin the block drives
  assign #DLY e_lvl = e_oe ? e_out : e_drv;
  assign #DLY f_lvl = (f_oe & f_out) | (~f_oe & f_drv);
endmodule : ppm_board
`default_nettype wire

/* File: testbench/ppm_port_mux_chk.sv */
/*
 * checker for the port pin mux: read slot timing, read gating and
 * the causes of output changes.
 * assumes it is bound to ppm_port_mux and sees only its ports.
 */
`timescale 1ns/10ps
`default_nettype none
module ppm_port_mux_chk (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ppm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ppm_pkg::DATA_W-1:0] reg_rdata,
  input wire logic e_top_pin_in,
  input wire logic [7:1] f_pin_oe,
  input wire logic ccp_b_capture,
  input wire logic [1:0] comp_enable,
  input wire logic e_pullup_en
);
  import ppm_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ************************************************************
  // properties
  // ************************************************************
  property p_rd_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_unmapped;
    reg_rd && reg_addr == 4'hf |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_pe_low;
    reg_rd && reg_addr == REG_PE_LEVELS |=> reg_rdata[6:0] == 7'h00;
  endproperty
  a_pe_low: assert property (p_pe_low) else $error("absent port e bits read");
  property p_cmp_read;
    reg_rd && reg_addr == REG_PF_LEVELS && comp_enable[1]
      |=> reg_rdata[4:3] == 2'b00 && !reg_rdata[0];
  endproperty
  a_cmp_read: assert property (p_cmp_read) else $error("comparator pin read high");
  property p_cmp_cause;
    $changed(comp_enable) |-> $past(reg_wr) && $past(reg_addr) == REG_CMP_CTRL;
  endproperty
  a_cmp_cause: assert property (p_cmp_cause) else $error("comparator enable moved");
  property p_pu_cause;
    $changed(e_pullup_en) |-> $past(reg_wr) && $past(reg_addr) == REG_PAD_CFG;
  endproperty
  a_pu_cause: assert property (p_pu_cause) else $error("pull-up enable moved");
  property p_oe_cause;
    $changed(f_pin_oe) |-> $past(reg_wr);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("port f enable moved");
  property p_cap_lat;
    $rose(ccp_b_capture) |-> $past(e_top_pin_in, 3);
  endproperty
  a_cap_lat: assert property (p_cap_lat) else $error("capture without pin high");
  property p_rst_in;
    $rose(rst_n) |-> f_pin_oe == 7'h00 && !ccp_b_capture;
  endproperty
  a_rst_in: assert property (p_rst_in) else $error("pins not inputs at reset");
endmodule : ppm_port_mux_chk
bind ppm_port_mux ppm_port_mux_chk u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .e_top_pin_in(e_top_pin_in),
  .f_pin_oe(f_pin_oe), .ccp_b_capture(ccp_b_capture), .comp_enable(comp_enable),
  .e_pullup_en(e_pullup_en)
);
`default_nettype wire
